//--- bench/mwm_bus_model.sv
// Behavioural controller and terminals driving the differential pair
`timescale 1ns/1ps
module mwm_bus_model #(
	parameter int HB = 25
) (
	input  wire logic clk,
	output logic      bus_pos,
	output logic      bus_neg
);
	initial begin
		bus_pos = 1'h0;
		bus_neg = 1'h0;
	end
	// One level for n clocks, entered just after a rising edge
	task automatic lvl(input logic hi, input int n);
		bus_pos <= hi;
		bus_neg <= !hi;
		repeat (n) @(posedge clk);
	endtask
	// Released pair sits at null so no stale level lingers
	task automatic idle(input int n);
		bus_pos <= 1'h0;
		bus_neg <= 1'h0;
		repeat (n) @(posedge clk);
	endtask
	// Gap, sync, sixteen bits MSB first, parity; bad_cell picks a cell with no mid edge
	task automatic send(input logic cs, input logic [15:0] d, input logic bad_par,
		input int bad_cell);
		logic [16:0] w;
		w = {d, ~^d ^ bad_par};
		idle(4 * HB);
		lvl(cs, 3 * HB);
		lvl(!cs, 3 * HB);
		for (int i = 16; i >= 0; i--) begin
			lvl(w[i], HB);
			lvl(w[i] ^ (i != bad_cell), HB);
		end
		// Transmitter lets go of the pair once the parity cell ends
		bus_pos <= 1'h0;
		bus_neg <= 1'h0;
	endtask
endmodule

//--- bench/mwm_word_monitor_properties.sv
// Checker on the decoded word outputs of the monitor
`timescale 1ns/1ps
module mwm_chk (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        word_valid,
	input wire logic [1:0]  word_type,
	input wire logic [15:0] word_data,
	input wire logic        sync_err,
	input wire logic [4:0]  rt_addr,
	input wire logic        tr_bit,
	input wire logic [4:0]  subaddr,
	input wire logic [5:0]  word_count,
	input wire logic        mode_cmd,
	input wire logic [4:0]  mode_code,
	input wire logic        bcast_cmd,
	input wire logic        st_msg_err,
	input wire logic        st_instr,
	input wire logic        st_svc_req,
	input wire logic [2:0]  st_reserved,
	input wire logic        st_bcast_rcvd,
	input wire logic        st_busy,
	input wire logic        st_subsys_flag,
	input wire logic        st_dyn_bus_acc,
	input wire logic        st_term_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire cw = word_valid && word_type == mwm_pkg::MWM_WT_CMD;
	wire sw = word_valid && word_type == mwm_pkg::MWM_WT_STAT;
	wire dw = word_valid && word_type == mwm_pkg::MWM_WT_DATA;
	wire [10:0] sbits = {st_msg_err, st_instr, st_svc_req, st_reserved, st_bcast_rcvd, st_busy,
		st_subsys_flag, st_dyn_bus_acc, st_term_flag};
	// A word lasts twenty bit times, so two pulses can never be close
	chk_valid_spacing: assert property (word_valid |=> !word_valid [*8])
		else $error("word pulses too close");
	chk_type_known: assert property (word_valid |-> word_type != mwm_pkg::MWM_WT_NONE)
		else $error("word without a type");
	chk_cmd_fields: assert property (cw |-> rt_addr == word_data[15:11] &&
		tr_bit == word_data[10] && subaddr == word_data[9:5]) else $error("command fields wrong");
	chk_mode_select: assert property (cw |-> mode_cmd ==
		(subaddr == 5'h00 || subaddr == 5'h1F)) else $error("mode flag wrong");
	chk_mode_code: assert property (cw && mode_cmd |-> word_count == 6'h00 &&
		mode_code == word_data[4:0]) else $error("mode code wrong");
	chk_count_decode: assert property (cw && !mode_cmd |-> word_count ==
		((word_data[4:0] == 5'h00) ? 6'h20 : {1'h0, word_data[4:0]})) else $error("count wrong");
	chk_bcast_flag: assert property (cw |-> bcast_cmd == (word_data[15:11] == 5'h1F))
		else $error("broadcast flag wrong");
	chk_status_bits: assert property (sw |->
		sbits == word_data[10:0] && rt_addr == word_data[15:11])
		else $error("status bits wrong");
	chk_status_instr: assert property (sw |-> !st_instr)
		else $error("status with instrumentation set");
	chk_data_held: assert property (dw |=> $stable(word_data) [*8])
		else $error("data payload not held");
	chk_sync_pulse: assert property ($rose(sync_err) |=> !sync_err)
		else $error("sync error longer than one cycle");
	cover property (cw && mode_cmd);
	cover property (sw);
	cover property (dw);
	cover property (sync_err);
endmodule

//--- bench/mwm_word_monitor_test.sv
// Self-checking bench for the word monitor
`timescale 1ns/1ps
`include "mwm_defines.svh"
module mwm_word_monitor_test;
	logic        clk, rst_n, ce, bus_pos, bus_neg, avs_read, avs_write, avs_waitrequest;
	logic        word_valid, parity_err, manch_err, sync_err, tr_bit, mode_cmd, bcast_cmd;
	logic        st_msg_err, st_instr, st_svc_req, st_bcast_rcvd, st_busy;
	logic        st_subsys_flag, st_dyn_bus_acc, st_term_flag, cs;
	logic [7:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0]  avs_byteenable;
	logic [1:0]  word_type, lt;
	logic [15:0] word_data, ld, d;
	logic [4:0]  rt_addr, subaddr, mode_code;
	logic [5:0]  word_count;
	logic [2:0]  st_reserved;
	int          n_mismatch, samples_checked, n_sync, n_v, n_sent, seed, prev_nb, v0;
	logic [15:0] fix [5] = '{16'h0800, 16'h0800, 16'h0BE5, 16'hFA2A, 16'h0820};

	mwm_word_monitor dut (.*);
	mwm_bus_model bm (.clk(clk), .bus_pos(bus_pos), .bus_neg(bus_neg));

	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		n_sync += (sync_err === 1'h1);
		n_v += (word_valid === 1'h1);
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int i;
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (avs_waitrequest !== 1'h0 && i < 20);
		if (avs_waitrequest !== 1'h0) begin
			n_mismatch++;
			finish_test();
		end
		rd = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		@(posedge clk);
	endtask
	// Send one word and compare every field with the bench's own decode
	task automatic word(input logic c, input logic [15:0] w, input logic bp, input int bc,
		input logic sw);
		int i, t, mc;
		logic [10:0] s;
		// With the wires swapped every level flips, parity bit included
		bm.send(c ^ sw, w ^ {16{sw}}, bp ^ sw, bc);
		n_sent++;
		t = !c ? 3 : (prev_nb && !w[9]) ? 2 : 1;
		if (c) prev_nb = (t == 1 && w[15:11] != 5'h1F);
		mc = (w[9:5] == 5'h00 || w[9:5] == 5'h1F);
		for (i = 0; i < 300 && word_valid !== 1'h1; i++) @(posedge clk);
		if (i == 300) begin
			n_mismatch++;
			finish_test();
		end
		s = {st_msg_err, st_instr, st_svc_req, st_reserved, st_bcast_rcvd, st_busy,
			st_subsys_flag, st_dyn_bus_acc, st_term_flag};
		lt = t;
		ld = w;
		chk("type", word_type, t);
		chk("data", word_data, w);
		chk("parity", parity_err, bp);
		chk("manch", manch_err, bc >= 0);
		if (t == 1) begin
			chk("addr", rt_addr, w[15:11]);
			chk("dir", tr_bit, w[10]);
			chk("sub", subaddr, w[9:5]);
			chk("mode", mode_cmd, mc);
			chk("count", word_count, mc ? 0 : (w[4:0] == 5'h00) ? 32 : w[4:0]);
			if (mc) chk("mcode", mode_code, w[4:0]);
			chk("bcast", bcast_cmd, w[15:11] == 5'h1F);
		end
		if (t == 2) begin
			chk("saddr", rt_addr, w[15:11]);
			chk("status", s, w[10:0]);
		end
	endtask

	initial begin
		seed = 32'hCE51CC7A;
		rst_n = 1'h0;
		ce = 1'h1;
		avs_read = 1'h0;
		avs_write = 1'h0;
		avs_address = 8'h00;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		repeat (4) @(posedge clk);
		av(1'h0, `MWM_REG_CTRL, 32'h0);
		chk("ctrl", rd, 32'h1);
		av(1'h1, 8'h40, 32'hFFFFFFFF);
		av(1'h0, 8'h40, 32'h0);
		chk("unmapped", rd, 32'h0);
		$display("registers test done");
		// Boundary command and status words first, then random words of either polarity
		for (int k = 0; k < 20; k++) begin
			d = $random(seed);
			cs = $random(seed);
			if (k < 5) d = fix[k];
			if (k < 6) cs = (k < 5);
			word(cs, d, 1'h0, -1, 1'h0);
		end
		av(1'h0, `MWM_REG_WCNT, 32'h0);
		chk("wcnt", rd, n_sent);
		av(1'h0, `MWM_REG_LAST, 32'h0);
		chk("last", rd, {14'h0, lt, ld});
		$display("word decode test done");
		// Parity, coding and sync faults, each seen in the sticky flags then cleared
		for (int e = 0; e < 3; e++) begin
			if (e == 0) word(1'h0, 16'h1234, 1'h1, -1, 1'h0);
			if (e == 1) word(1'h0, 16'h0000, 1'h0, 3, 1'h0);
			if (e == 2) begin
				bm.lvl(1'h1, 150);
				bm.idle(200);
				chk("sync_err", n_sync, 1);
				// A proper first half whose second half collapses to null
				bm.lvl(1'h1, 75);
				bm.lvl(1'h0, 20);
				bm.idle(200);
				chk("sync_half", n_sync, 2);
			end
			av(1'h0, `MWM_REG_ERR, 32'h0);
			chk("err", rd, 1 << e);
			av(1'h1, `MWM_REG_ERR, 32'h7);
			av(1'h0, `MWM_REG_ERR, 32'h0);
			chk("err_clr", rd, 32'h0);
		end
		$display("fault test done");
		// A low clock enable freezes the monitor through a stuck level
		v0 = n_sync;
		ce <= 1'h0;
		bm.lvl(1'h1, 150);
		bm.idle(10);
		ce <= 1'h1;
		bm.idle(10);
		chk("frozen", n_sync - v0, 0);
		// With the monitor disabled a clean word must pass unseen
		av(1'h1, `MWM_REG_CTRL, 32'h0);
		v0 = n_v;
		bm.send(1'h1, 16'h0821, 1'h0, -1);
		repeat (50) @(posedge clk);
		chk("disabled", n_v - v0, 0);
		av(1'h1, `MWM_REG_CTRL, 32'h3);
		word(1'h1, 16'h0821, 1'h0, -1, 1'h1);
		av(1'h1, `MWM_REG_CTRL, 32'h1);
		$display("enable test done");
		finish_test();
	end
endmodule

bind mwm_word_monitor mwm_chk u_chk (.*);

//--- core/mwm_defines.svh
// Constants for the serial avionics bus word monitor: timing, fields, register map
`ifndef MWM_DEFINES_SVH
`define MWM_DEFINES_SVH

// Timing
`define MWM_CLK_MHZ          50
`define MWM_HALF_BIT_NS      500
`define MWM_NS_PER_US        1000
`define MWM_SYNC_HALVES      3
`define MWM_SYNC_TOL_LO_X2   5
`define MWM_SYNC_TOL_HI_X2   7
`define MWM_BIT_CELLS        17
`define MWM_RUN_SAT          8'hFF

// Word layout, bit 0 is the last information bit sent
`define MWM_W_ADDR_HI        15
`define MWM_W_ADDR_LO        11
`define MWM_CW_TR            10
`define MWM_CW_SA_HI         9
`define MWM_CW_SA_LO         5
`define MWM_CW_CNT_HI        4
`define MWM_CW_CNT_LO        0
`define MWM_SW_MSG_ERR       10
`define MWM_SW_INSTR         9
`define MWM_SW_SVC_REQ       8
`define MWM_SW_RSV_HI        7
`define MWM_SW_RSV_LO        5
`define MWM_SW_BCAST         4
`define MWM_SW_BUSY          3
`define MWM_SW_SUBSYS        2
`define MWM_SW_DYN_BUS       1
`define MWM_SW_TERM          0
`define MWM_BCAST_ADDR       5'h1F
`define MWM_MODE_SA_LO       5'h00
`define MWM_MODE_SA_HI       5'h1F
`define MWM_CNT_ZERO         5'h00
`define MWM_CNT_ZERO_AS      6'h20

// Register map, byte addresses
`define MWM_REG_CTRL         8'h00
`define MWM_REG_ERR          8'h04
`define MWM_REG_LAST         8'h08
`define MWM_REG_CMD          8'h0C
`define MWM_REG_STAT         8'h10
`define MWM_REG_WCNT         8'h14
`define MWM_CTRL_EN          0
`define MWM_CTRL_INV         1
`define MWM_CTRL_RST         2'h1
`define MWM_ERR_PAR          0
`define MWM_ERR_MAN          1
`define MWM_ERR_SYNC         2

`endif

//--- core/mwm_pkg.sv
// Types shared by the word monitor
package mwm_pkg;

	typedef enum logic [2:0] {
		MWM_ST_IDLE = 3'h1,
		MWM_ST_SYNC = 3'h2,
		MWM_ST_BITS = 3'h4
	} mwm_state_t;

	typedef enum logic [1:0] {
		MWM_LVL_NULL = 2'h0,
		MWM_LVL_HI   = 2'h1,
		MWM_LVL_LO   = 2'h2
	} mwm_lvl_t;

	typedef enum logic [1:0] {
		MWM_WT_NONE = 2'h0,
		MWM_WT_CMD  = 2'h1,
		MWM_WT_STAT = 2'h2,
		MWM_WT_DATA = 2'h3
	} mwm_word_t;

endpackage

//--- core/mwm_word_monitor.sv
// Passive Manchester word monitor with decoded fields and an Avalon-MM register slave
// Notes on behaviour
// - One is high-then-low, zero is low-then-high
// - Each word starts with a non-Manchester sync
// - Every word is command, data or status
// - Extract five-bit terminal address, 31 terminals
// - Extract five-bit subaddress of command words
// - Subaddress 0 or 31 means mode code
// - Word count gives data words, up to 32
// - Mode commands report count field as mode
// - Decode the transmit/receive direction bit
// - Odd parity over word; even count flags error
// - Data word gives its sixteen-bit payload
// - Report the status message error bit
// - Terminal keeps instrumentation bit zero in status
// - Report the status service request bit
// - Report the status broadcast-received bit
// - Report the status busy bit
// - Report the status subsystem flag bit
// - Report the dynamic bus control acceptance bit
// - Report the status terminal flag bit
// - Reserved status bits passed through uninterpreted
// - Listen only, never transmit on bus
// - Missing mid-cell transition flags Manchester error
// - Misshapen second sync half, or a level stuck beyond any sync length, flags a sync error
`timescale 1ns/1ps
`include "mwm_defines.svh"

module mwm_word_monitor #(
	parameter int CLK_MHZ = `MWM_CLK_MHZ
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic        bus_pos,
	input  wire logic        bus_neg,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic             word_valid,
	output logic      [1:0]  word_type,
	output logic      [15:0] word_data,
	output logic             parity_err,
	output logic             manch_err,
	output logic             sync_err,
	output logic      [4:0]  rt_addr,
	output logic             tr_bit,
	output logic      [4:0]  subaddr,
	output logic      [5:0]  word_count,
	output logic             mode_cmd,
	output logic      [4:0]  mode_code,
	output logic             bcast_cmd,
	output logic             st_msg_err,
	output logic             st_instr,
	output logic             st_svc_req,
	output logic      [2:0]  st_reserved,
	output logic             st_bcast_rcvd,
	output logic             st_busy,
	output logic             st_subsys_flag,
	output logic             st_dyn_bus_acc,
	output logic             st_term_flag
);

	localparam int HALF_CYC = (`MWM_HALF_BIT_NS * CLK_MHZ) / `MWM_NS_PER_US;
	localparam logic [7:0] C_S1       = 8'(HALF_CYC / 2);
	localparam logic [7:0] C_S2       = 8'(HALF_CYC + HALF_CYC / 2);
	localparam logic [7:0] C_S3       = 8'(2 * HALF_CYC + HALF_CYC / 2);
	localparam logic [7:0] C_CELL_END = 8'(2 * HALF_CYC - 1);
	localparam logic [7:0] C_SYNC_END = 8'(`MWM_SYNC_HALVES * HALF_CYC - 1);
	localparam logic [7:0] C_SYNC_MIN = 8'((`MWM_SYNC_TOL_LO_X2 * HALF_CYC) / 2);
	localparam logic [7:0] C_SYNC_MAX = 8'((`MWM_SYNC_TOL_HI_X2 * HALF_CYC) / 2);
	localparam logic [4:0] C_LAST_BIT = 5'(`MWM_BIT_CELLS - 1);
	// Run and cell counters are eight bits; the longest run must fit below saturation
	if (HALF_CYC < 4 || `MWM_SYNC_TOL_HI_X2 * HALF_CYC / 2 + 1 >= 255) begin : g_chk
		$error("CLK_MHZ gives a half-bit count the decoder cannot serve");
	end
	function automatic mwm_pkg::mwm_lvl_t line_lvl(
		input logic p,
		input logic n,
		input logic inv
	);
		if (p == n)
			line_lvl = mwm_pkg::MWM_LVL_NULL;
		else if (p ^ inv)
			line_lvl = mwm_pkg::MWM_LVL_HI;
		else
			line_lvl = mwm_pkg::MWM_LVL_LO;
	endfunction
	function automatic logic is_sync_sample(input logic [7:0] c);
		is_sync_sample = (c == C_S1) || (c == C_S2) || (c == C_S3);
	endfunction

	// Pin synchronisers
	logic pos_m_q;
	logic pos_s_q;
	logic neg_m_q;
	logic neg_s_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pos_m_q <= 1'b0;
			pos_s_q <= 1'b0;
			neg_m_q <= 1'b0;
			neg_s_q <= 1'b0;
		end else if (ce) begin
			pos_m_q <= bus_pos;
			pos_s_q <= pos_m_q;
			neg_m_q <= bus_neg;
			neg_s_q <= neg_m_q;
		end
	end

	logic [1:0]          ctrl_q;
	mwm_pkg::mwm_lvl_t   cur_lvl;
	mwm_pkg::mwm_lvl_t   lvl_q;
	logic [7:0]          run_q;
	mwm_pkg::mwm_state_t state_q;
	logic [7:0]          cnt_q;
	logic [4:0]          bit_idx_q;
	logic                cs_sync_q;
	mwm_pkg::mwm_lvl_t   h1_q;
	mwm_pkg::mwm_lvl_t   sync_exp_q;
	logic [16:0]         sh_q;
	logic                manch_bad_q;
	logic                sync_bad;
	logic                sync_start;
	logic                word_done;
	logic                bit_one;
	logic                bit_zero;
	logic [15:0]         wdata;
	logic                par_ok;
	logic                exp_status_q;
	logic                is_status;
	assign cur_lvl = line_lvl(pos_s_q, neg_s_q, ctrl_q[`MWM_CTRL_INV]);
	// Sync start: a full-length run of one level ends in the opposite level
	assign sync_start = (state_q == mwm_pkg::MWM_ST_IDLE) && ctrl_q[`MWM_CTRL_EN]
		&& (lvl_q != mwm_pkg::MWM_LVL_NULL) && (cur_lvl != mwm_pkg::MWM_LVL_NULL)
		&& (cur_lvl != lvl_q) && (run_q >= C_SYNC_MIN) && (run_q <= C_SYNC_MAX);

	// Misshapen second sync half, or a level stuck beyond any sync length
	assign sync_bad = ((state_q == mwm_pkg::MWM_ST_SYNC) && is_sync_sample(cnt_q)
		&& (cur_lvl != sync_exp_q))
		|| ((state_q == mwm_pkg::MWM_ST_IDLE) && ctrl_q[`MWM_CTRL_EN]
		&& (lvl_q != mwm_pkg::MWM_LVL_NULL) && (run_q == C_SYNC_MAX + 8'h01));

	assign bit_one  = (h1_q == mwm_pkg::MWM_LVL_HI) && (cur_lvl == mwm_pkg::MWM_LVL_LO);
	assign bit_zero = (h1_q == mwm_pkg::MWM_LVL_LO) && (cur_lvl == mwm_pkg::MWM_LVL_HI);
	assign word_done = (state_q == mwm_pkg::MWM_ST_BITS) && (cnt_q == C_CELL_END)
		&& (bit_idx_q == C_LAST_BIT);
	assign wdata  = sh_q[16:1];
	assign par_ok = ^sh_q;

	// A status word can only follow a command, and its instrumentation bit is zero
	assign is_status = exp_status_q && !wdata[`MWM_SW_INSTR];

	// Line level and run length since the last change or word end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lvl_q <= mwm_pkg::MWM_LVL_NULL;
			run_q <= 8'h00;
		end else if (ce) begin
			lvl_q <= cur_lvl;
			if (word_done || cur_lvl != lvl_q)
				run_q <= 8'h00;
			else if (run_q != `MWM_RUN_SAT)
				run_q <= run_q + 8'h01;
		end
	end

	// Word framer: sync check, then half-bit sampling of each cell
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q     <= mwm_pkg::MWM_ST_IDLE;
			cnt_q       <= 8'h00;
			bit_idx_q   <= 5'h00;
			cs_sync_q   <= 1'b0;
			h1_q        <= mwm_pkg::MWM_LVL_NULL;
			sync_exp_q  <= mwm_pkg::MWM_LVL_NULL;
			sh_q        <= 17'h00000;
			manch_bad_q <= 1'b0;
		end else if (ce) begin
			case (state_q)
				mwm_pkg::MWM_ST_IDLE: begin
					if (sync_start) begin
						state_q     <= mwm_pkg::MWM_ST_SYNC;
						cs_sync_q   <= (lvl_q == mwm_pkg::MWM_LVL_HI);
						sync_exp_q  <= cur_lvl;
						cnt_q       <= 8'h00;
						manch_bad_q <= 1'b0;
					end
				end
				mwm_pkg::MWM_ST_SYNC: begin
					if (sync_bad) begin
						state_q <= mwm_pkg::MWM_ST_IDLE;
					end else if (cnt_q == C_SYNC_END) begin
						state_q   <= mwm_pkg::MWM_ST_BITS;
						cnt_q     <= 8'h00;
						bit_idx_q <= 5'h00;
					end else begin
						cnt_q <= cnt_q + 8'h01;
					end
				end
				mwm_pkg::MWM_ST_BITS: begin
					if (cnt_q == C_S1)
						h1_q <= cur_lvl;
					if (cnt_q == C_S2) begin
						sh_q <= {sh_q[15:0], bit_one};
						if (!(bit_one || bit_zero))
							manch_bad_q <= 1'b1;
					end
					if (cnt_q == C_CELL_END) begin
						cnt_q     <= 8'h00;
						bit_idx_q <= bit_idx_q + 5'h01;
						if (bit_idx_q == C_LAST_BIT)
							state_q <= mwm_pkg::MWM_ST_IDLE;
					end else begin
						cnt_q <= cnt_q + 8'h01;
					end
				end
				default: begin
					state_q <= mwm_pkg::MWM_ST_IDLE;
				end
			endcase
		end
	end

	// Message sequence: after a non-broadcast command a status answer may follow.
	// Limitation: a terminal-to-terminal transfer can still look like a status word.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			exp_status_q <= 1'b0;
		end else if (ce && word_done && cs_sync_q) begin
			if (is_status)
				exp_status_q <= 1'b0;
			else
				exp_status_q <= (wdata[`MWM_W_ADDR_HI:`MWM_W_ADDR_LO] != `MWM_BCAST_ADDR);
		end
	end

	// Word level outputs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			word_valid <= 1'b0;
			word_type  <= mwm_pkg::MWM_WT_NONE;
			word_data  <= 16'h0000;
			parity_err <= 1'b0;
			manch_err  <= 1'b0;
			sync_err   <= 1'b0;
		end else if (ce) begin
			word_valid <= word_done;
			sync_err   <= sync_bad;
			if (word_done) begin
				word_data  <= wdata;
				parity_err <= !par_ok;
				manch_err  <= manch_bad_q;
				if (!cs_sync_q)
					word_type <= mwm_pkg::MWM_WT_DATA;
				else if (is_status)
					word_type <= mwm_pkg::MWM_WT_STAT;
				else
					word_type <= mwm_pkg::MWM_WT_CMD;
			end
		end
	end

	// Command fields
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rt_addr    <= 5'h00;
			tr_bit     <= 1'b0;
			subaddr    <= 5'h00;
			word_count <= 6'h00;
			mode_cmd   <= 1'b0;
			mode_code  <= 5'h00;
			bcast_cmd  <= 1'b0;
		end else if (ce && word_done && cs_sync_q) begin
			rt_addr <= wdata[`MWM_W_ADDR_HI:`MWM_W_ADDR_LO];
			if (!is_status) begin
				tr_bit    <= wdata[`MWM_CW_TR];
				subaddr   <= wdata[`MWM_CW_SA_HI:`MWM_CW_SA_LO];
				bcast_cmd <= (wdata[`MWM_W_ADDR_HI:`MWM_W_ADDR_LO] == `MWM_BCAST_ADDR);
				if (wdata[`MWM_CW_SA_HI:`MWM_CW_SA_LO] == `MWM_MODE_SA_LO
					|| wdata[`MWM_CW_SA_HI:`MWM_CW_SA_LO] == `MWM_MODE_SA_HI) begin
					mode_cmd   <= 1'b1;
					mode_code  <= wdata[`MWM_CW_CNT_HI:`MWM_CW_CNT_LO];
					word_count <= 6'h00;
				end else begin
					mode_cmd  <= 1'b0;
					mode_code <= 5'h00;
					if (wdata[`MWM_CW_CNT_HI:`MWM_CW_CNT_LO] == `MWM_CNT_ZERO)
						word_count <= `MWM_CNT_ZERO_AS;
					else
						word_count <= {1'b0, wdata[`MWM_CW_CNT_HI:`MWM_CW_CNT_LO]};
				end
			end
		end
	end

	// Status fields, reserved bits passed as received
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_msg_err     <= 1'b0;
			st_instr       <= 1'b0;
			st_svc_req     <= 1'b0;
			st_reserved    <= 3'h0;
			st_bcast_rcvd  <= 1'b0;
			st_busy        <= 1'b0;
			st_subsys_flag <= 1'b0;
			st_dyn_bus_acc <= 1'b0;
			st_term_flag   <= 1'b0;
		end else if (ce && word_done && cs_sync_q && is_status) begin
			st_msg_err     <= wdata[`MWM_SW_MSG_ERR];
			st_instr       <= wdata[`MWM_SW_INSTR];
			st_svc_req     <= wdata[`MWM_SW_SVC_REQ];
			st_reserved    <= wdata[`MWM_SW_RSV_HI:`MWM_SW_RSV_LO];
			st_bcast_rcvd  <= wdata[`MWM_SW_BCAST];
			st_busy        <= wdata[`MWM_SW_BUSY];
			st_subsys_flag <= wdata[`MWM_SW_SUBSYS];
			st_dyn_bus_acc <= wdata[`MWM_SW_DYN_BUS];
			st_term_flag   <= wdata[`MWM_SW_TERM];
		end
	end

	// Register slave: one wait cycle, then the access completes.
	// The monitor has no driver on the bus pins at all.
	logic [2:0]  err_q;
	logic [2:0]  err_set;
	logic [2:0]  err_clr;
	logic [15:0] stat_word_q;
	logic [31:0] wcnt_q;
	logic        wr_go;
	assign wr_go   = avs_write && !avs_waitrequest;
	assign err_set = {sync_bad, word_done && manch_bad_q, word_done && !par_ok};
	assign err_clr = (wr_go && avs_address == `MWM_REG_ERR && avs_byteenable[0])
		? avs_writedata[2:0] : 3'h0;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
		end else if (ce) begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_q <= `MWM_CTRL_RST;
		end else if (ce && wr_go && avs_address == `MWM_REG_CTRL && avs_byteenable[0]) begin
			ctrl_q <= avs_writedata[1:0];
		end
	end
	// Hardware set wins over a software clear in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			err_q <= 3'h0;
		end else if (ce) begin
			err_q <= (err_q & ~err_clr) | err_set;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stat_word_q <= 16'h0000;
			wcnt_q      <= 32'h00000000;
		end else if (ce && word_done) begin
			wcnt_q <= wcnt_q + 32'h00000001;
			if (cs_sync_q && is_status)
				stat_word_q <= wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			avs_readdata <= 32'h00000000;
		end else if (ce && avs_read && avs_waitrequest) begin
			case (avs_address)
				`MWM_REG_CTRL: avs_readdata <= {30'h00000000, ctrl_q};
				`MWM_REG_ERR:  avs_readdata <= {29'h00000000, err_q};
				`MWM_REG_LAST: avs_readdata <= {12'h000, manch_err, parity_err, word_type,
					word_data};
				`MWM_REG_CMD:  avs_readdata <= {8'h00, bcast_cmd, mode_code, mode_cmd,
					word_count, subaddr, tr_bit, rt_addr};
				`MWM_REG_STAT: avs_readdata <= {16'h0000, stat_word_q};
				`MWM_REG_WCNT: avs_readdata <= wcnt_q;
				default:       avs_readdata <= 32'h00000000;
			endcase
		end
	end

endmodule
